//--- core/ddr_dual_pkg.sv
// Shared constants for the double-rate dual-line flash read link.
// Assumes a single 125 MHz system clock on both ends of the link.
package ddr_dual_pkg;

  // ---------------------------------------------------------------
  // Command set and frame shape
  // ---------------------------------------------------------------
  localparam logic [7:0] OPC_DUAL_DDR = 8'hBD;
  localparam logic [7:0] OPC_DUAL_DDR_4B = 8'hBE;
  localparam logic [19:0] OPCODE_EDGES = 20'h00010;
  localparam logic [19:0] ADDR3_EDGES = 20'h0000C;
  localparam logic [19:0] ADDR4_EDGES = 20'h00010;
  localparam logic [19:0] MODE_EDGES = 20'h00004;
  localparam logic [19:0] PREAMBLE_EDGES = 20'h00008;
  localparam logic [7:0] PATTERN_RESET = 8'h34;
  localparam int LC_W = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int SCK_MAX_MHZ = 80;
  // Least half period of the serial clock in system cycles, rounded up.
  localparam int SCK_HALF_MIN = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam int SCK_HALF_DEFAULT = 8;
  localparam int HC_W = 4;

  // ---------------------------------------------------------------
  // Host register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_PATTERN = 8'h10;
  localparam int CTRL_START = 0;
  localparam int CTRL_BE = 1;
  localparam int CTRL_EXT = 2;
  localparam int CTRL_ENH = 3;
  localparam int CTRL_CONT = 4;
  localparam int CTRL_PAT = 5;
  localparam int CTRL_MODE_LSB = 8;
  localparam int CTRL_DUMMY_LSB = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_VALID = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_LEARNED = 3;
  localparam int STAT_DATA_LSB = 8;
  localparam int STAT_SKEW_LSB = 16;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;

  // Dummy clocks per latency code; the enhanced table leaves room for mode cycles.
  function automatic logic [4:0] dummy_cycles(input logic enh, input logic [LC_W-1:0] code);
    logic [4:0] d;
    d = 5'h08;
    case ({enh, code})
      3'h0: d = 5'h05;
      3'h1: d = 5'h06;
      3'h2: d = 5'h07;
      3'h3: d = 5'h08;
      3'h4: d = 5'h04;
      3'h5: d = 5'h05;
      3'h6: d = 5'h06;
      default: d = 5'h07;
    endcase
    return d;
  endfunction

endpackage

//--- core/ddr_dual_link_if.sv
// Link between the dual-line flash host and the flash device.
// Assumes both ends run on one clock; the lines have a weak pull-up.
`timescale 1ns/1ps
`default_nettype none
interface ddr_dual_link_if;
  logic cs_b;
  logic sck;
  logic [1:0] host_io_o;
  logic [1:0] host_io_oe;
  logic [1:0] dev_io_o;
  logic [1:0] dev_io_oe;
  logic [1:0] io;

  // Resolved line level; an undriven line floats high.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      io[i] = dev_io_oe[i] ? dev_io_o[i] : (host_io_oe[i] ? host_io_o[i] : 1'b1);
    end
  end

  modport host (output cs_b, output sck, output host_io_o, output host_io_oe, input io);
  modport device (input cs_b, input sck, output dev_io_o, output dev_io_oe, input io);
endinterface
`default_nettype wire

//--- core/ddr_dual_array.sv
// Read-only array contents of the flash device, as a fixed function of the address.
// Assumes the caller registers the byte it takes.
`timescale 1ns/1ps
`default_nettype none
module ddr_dual_array #(
  parameter int ADDR_W = 26
) (
  // Address in, byte out
  input wire logic [ADDR_W-1:0] addr,
  output logic [7:0] data
);
  import ddr_dual_pkg::*;

  // Fold every address bit into the byte so neighbouring bytes differ, except where adding one flips exactly 16 bits, as from 7FFFh to 8000h.
  always_comb begin
    data = 8'h5A;
    for (int i = 0; i < ADDR_W; i++) begin
      data[i % 8] = data[i % 8] ^ addr[i];
    end
  end
endmodule
`default_nettype wire

//--- core/ddr_dual_flash_dev.sv
// Flash device end of the double-rate dual-line read command.
// Assumes the link pins arrive asynchronously and are oversampled by clk.
//
// Contract
// - BDh with extended setting 0: 3-byte address
// - BDh with extended setting 1: 4-byte address
// - BEh always takes a 4-byte address
// - Data out two bits each clock edge
// - Address and mode two bits each edge
// - Host keeps serial clock at 80 MHz max
// - Latency code selects dummy clocks before data
// - Base table: opcode, address, latency, no mode
// - Lines ignored during latency cycles
// - Host floats lines during dummy with preamble
// - Complementary mode nibbles enter continuous mode
// - Continuous mode: address follows select, no opcode
// - Non-complementary mode leaves continuous mode next select
// - Short select without valid sequence leaves continuous
// - Address increments after each output byte
// - Address wraps to zero past the top
// - Host keeps select low through mode, dummy
// - Pause input ignored during this command
// - Preamble on last four dummy clocks
// - Host releases lines before the preamble
// - Programmable pattern, same on both lines
// - Host learns capture skew from each preamble
`timescale 1ns/1ps
`default_nettype none
module ddr_dual_flash_dev #(
  parameter int ARRAY_ADDR_W = 26
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Link to the host
  ddr_dual_link_if.device link,
  // Configuration
  input wire logic extended_address_setting,
  input wire logic enhanced_latency_table,
  input wire logic [ddr_dual_pkg::LC_W-1:0] latency_code,
  input wire logic learning_pattern_en,
  input wire logic [7:0] learning_pattern,
  input wire logic pause_b,
  // Status
  output logic continuous_mode,
  output logic busy
);
  import ddr_dual_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPC, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } dev_state_type;

  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic cs_p;
    logic sck_m;
    logic sck_s;
    logic sck_p;
    logic [1:0] io_m;
    logic [1:0] io_s;
    dev_state_type st;
    logic [5:0] cnt;
    logic [7:0] sr;
    logic four_b;
    logic [ARRAY_ADDR_W-1:0] addr;
    logic [7:0] byte_sr;
    logic [1:0] out;
    logic oe;
    logic cont;
    logic mode_ok;
  } dev_regs_type;

  dev_regs_type s_q;
  dev_regs_type s_d;
  logic [7:0] array_byte;
  logic rise;
  logic fall;
  logic [5:0] lat_edges;
  logic [5:0] addr_edges;
  logic [7:0] opc;
  logic [7:0] mode;
  logic [2:0] pre_idx;
  logic [5:0] pre_first;

  ddr_dual_array #(.ADDR_W(ARRAY_ADDR_W)) u_array (
    .addr(s_q.addr),
    .data(array_byte)
  );

  // ---------------------------------------------------------------
  // Derived terms
  // ---------------------------------------------------------------
  // The pause pin is deliberately never looked at; a read cannot be held.
  assign rise = s_q.sck_s & ~s_q.sck_p;
  assign fall = ~s_q.sck_s & s_q.sck_p;
  assign lat_edges = {dummy_cycles(enhanced_latency_table, latency_code), 1'b0};
  assign addr_edges = s_q.four_b ? ADDR4_EDGES[5:0] : ADDR3_EDGES[5:0];
  assign opc = {s_q.sr[6:0], s_q.io_s[0]};
  assign mode = {s_q.sr[5:0], s_q.io_s};
  assign pre_first = lat_edges - PREAMBLE_EDGES[5:0];
  assign pre_idx = 3'(s_q.cnt - pre_first);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Every link pin goes through two flops, select and clock through a third; only the second and third stages feed logic.
  always_comb begin
    s_d = s_q;
    s_d.cs_m = link.cs_b;
    s_d.cs_s = s_q.cs_m;
    s_d.cs_p = s_q.cs_s;
    s_d.sck_m = link.sck;
    s_d.sck_s = s_q.sck_m;
    s_d.sck_p = s_q.sck_s;
    s_d.io_m = link.io;
    s_d.io_s = s_q.io_m;
    if (s_q.cs_s && !s_q.cs_p) begin
      // Select rise: continuous mode survives only a completed complementary mode byte.
      s_d.st = ST_IDLE;
      s_d.oe = 1'b0;
      s_d.cont = s_q.mode_ok;
      s_d.mode_ok = 1'b0;
    end else if (!s_q.cs_s && s_q.cs_p) begin
      s_d.st = s_q.cont ? ST_ADDR : ST_OPC;
      s_d.cnt = 6'h00;
      // A 3-byte address must not inherit upper bits from the previous read.
      s_d.addr = '0;
      s_d.mode_ok = 1'b0;
    end else if (!s_q.cs_s && (rise || fall)) begin
      case (s_q.st)
        ST_OPC: begin
          if (rise) begin
            s_d.sr = opc;
            s_d.cnt = s_q.cnt + 6'h01;
            if (s_q.cnt == 6'h07) begin
              s_d.cnt = 6'h00;
              s_d.st = ST_ADDR;
              if (opc == OPC_DUAL_DDR) begin
                s_d.four_b = extended_address_setting;
              end else if (opc == OPC_DUAL_DDR_4B) begin
                s_d.four_b = 1'b1;
              end else begin
                s_d.st = ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR: begin
          // Address starts on a rising edge; the falling edge after the opcode is idle.
          if (rise || s_q.cnt != 6'h00) begin
            s_d.addr = {s_q.addr[ARRAY_ADDR_W-3:0], s_q.io_s};
            s_d.cnt = s_q.cnt + 6'h01;
            if (s_q.cnt == addr_edges - 6'h01) begin
              s_d.cnt = 6'h00;
              s_d.st = enhanced_latency_table ? ST_MODE : ST_DUMMY;
            end
          end
        end
        ST_MODE: begin
          s_d.sr = mode;
          s_d.cnt = s_q.cnt + 6'h01;
          if (s_q.cnt == MODE_EDGES[5:0] - 6'h01) begin
            s_d.cnt = 6'h00;
            s_d.mode_ok = (mode[7:4] == ~mode[3:0]);
            s_d.st = ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          // Line levels are never sampled here.
          s_d.cnt = s_q.cnt + 6'h01;
          if (learning_pattern_en && s_q.cnt >= pre_first) begin
            s_d.oe = 1'b1;
            s_d.out = {2{learning_pattern[3'h7 - pre_idx]}};
          end
          if (s_q.cnt == lat_edges - 6'h01) begin
            s_d.cnt = 6'h00;
            s_d.st = ST_DATA;
          end
        end
        ST_DATA: begin
          s_d.oe = 1'b1;
          s_d.cnt = {4'h0, s_q.cnt[1:0] + 2'h1};
          if (s_q.cnt[1:0] == 2'h0) begin
            s_d.out = array_byte[7:6];
            s_d.byte_sr = {array_byte[5:0], 2'h0};
            s_d.addr = s_q.addr + ARRAY_ADDR_W'(1);
          end else begin
            s_d.out = s_q.byte_sr[7:6];
            s_d.byte_sr = {s_q.byte_sr[5:0], 2'h0};
          end
        end
        ST_IGNORE: begin
          s_d.st = ST_IGNORE;
        end
        default: begin
          s_d.st = ST_IDLE;
        end
      endcase
    end
  end

  // Register the whole state; the enable freezes everything.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{cs_m: 1'b1, cs_s: 1'b1, cs_p: 1'b1, st: ST_IDLE, default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.dev_io_o = s_q.out;
  assign link.dev_io_oe = {2{s_q.oe}};
  assign continuous_mode = s_q.cont;
  assign busy = (s_q.st != ST_IDLE);
endmodule
`default_nettype wire

//--- core/ddr_dual_flash_host.sv
// Host end: an APB-programmed controller that issues the dual-line double-rate read.
// Assumes APB runs on clk and the device end answers within a serial half period.
`timescale 1ns/1ps
`default_nettype none
module ddr_dual_flash_host #(
  parameter int SCK_HALF = ddr_dual_pkg::SCK_HALF_DEFAULT
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device
  ddr_dual_link_if.host link
);
  import ddr_dual_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic {H_IDLE, H_RUN} host_state_type;

  typedef struct packed {
    logic [1:0] io_m;
    logic [1:0] io_s;
    logic [31:0] ctrl;
    logic [31:0] addr;
    logic [15:0] len;
    logic [7:0] pattern;
    logic [31:0] rdata;
    host_state_type st;
    logic [HC_W-1:0] hc;
    logic [19:0] e;
    logic sck;
    logic cs_b;
    logic [7:0] op_sr;
    logic [39:0] sh;
    logic [1:0] out;
    logic [1:0] oe;
    logic [7:0] rsr;
    logic [1:0] dc;
    logic [7:0] rx;
    logic valid;
    logic overrun;
    logic found;
    logic learned;
    logic [HC_W-1:0] best;
    logic [HC_W-1:0] skew;
  } host_regs_type;

  host_regs_type s_q;
  host_regs_type s_d;
  logic setup;
  logic access;
  logic mapped;
  logic tick;
  logic [19:0] op_end;
  logic [19:0] md_end;
  logic [19:0] dm_end;
  logic [19:0] tot;
  logic [19:0] cur;
  logic [2:0] pidx;
  logic expect_bit;
  logic [7:0] mode_val;

  // ---------------------------------------------------------------
  // Frame layout in serial clock edges
  // ---------------------------------------------------------------
  assign op_end = s_q.ctrl[CTRL_CONT] ? 20'h00000 : OPCODE_EDGES;
  assign md_end = op_end + ((s_q.ctrl[CTRL_BE] || s_q.ctrl[CTRL_EXT]) ? ADDR4_EDGES : ADDR3_EDGES)
                  + (s_q.ctrl[CTRL_ENH] ? MODE_EDGES : 20'h00000);
  assign dm_end = md_end + {14'h0000, s_q.ctrl[CTRL_DUMMY_LSB +: 5], 1'b0};
  assign tot = dm_end + {2'h0, s_q.len, 2'h0};
  assign cur = s_q.e - 20'h00001;
  assign pidx = 3'(cur - (dm_end - PREAMBLE_EDGES));
  assign expect_bit = s_q.pattern[3'h7 - pidx];
  assign tick = (s_q.hc == HC_W'(SCK_HALF - 1));
  assign mode_val = s_q.ctrl[CTRL_MODE_LSB +: 8];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  // Zero wait states: read data is latched in the setup cycle.
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == REG_CTRL) || (paddr == REG_ADDR) || (paddr == REG_LEN)
                  || (paddr == REG_STATUS) || (paddr == REG_PATTERN);
  assign pready = access;
  assign pslverr = access & ~mapped;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.io_m = link.io;
    s_d.io_s = s_q.io_m;
    if (setup) begin
      case (paddr)
        REG_CTRL: s_d.rdata = s_q.ctrl;
        REG_ADDR: s_d.rdata = s_q.addr;
        REG_LEN: s_d.rdata = {16'h0000, s_q.len};
        REG_PATTERN: s_d.rdata = {24'h000000, s_q.pattern};
        REG_STATUS: begin
          s_d.rdata = 32'h00000000;
          s_d.rdata[STAT_BUSY] = (s_q.st == H_RUN);
          s_d.rdata[STAT_VALID] = s_q.valid;
          s_d.rdata[STAT_OVERRUN] = s_q.overrun;
          s_d.rdata[STAT_LEARNED] = s_q.learned;
          s_d.rdata[STAT_DATA_LSB +: 8] = s_q.rx;
          s_d.rdata[STAT_SKEW_LSB +: HC_W] = s_q.skew;
        end
        default: s_d.rdata = 32'h00000000;
      endcase
    end
    // Status read clears the byte flags; a byte landing the same cycle sets valid again below, overrun stays clear.
    if (access && !pwrite && paddr == REG_STATUS) begin
      s_d.valid = 1'b0;
      s_d.overrun = 1'b0;
    end
    if (access && pwrite && s_q.st == H_IDLE) begin
      case (paddr)
        REG_CTRL: s_d.ctrl = {pwdata[31:1], 1'b0};
        REG_ADDR: s_d.addr = pwdata;
        REG_LEN: s_d.len = pwdata[15:0];
        REG_PATTERN: s_d.pattern = pwdata[7:0];
        default: s_d.ctrl = s_q.ctrl;
      endcase
      if (paddr == REG_CTRL && pwdata[CTRL_START]) begin
        s_d.st = H_RUN;
        s_d.cs_b = 1'b0;
        s_d.hc = '0;
        s_d.e = 20'h00000;
        s_d.dc = 2'h0;
        s_d.op_sr = pwdata[CTRL_BE] ? OPC_DUAL_DDR_4B : OPC_DUAL_DDR;
        s_d.sh = (pwdata[CTRL_BE] || pwdata[CTRL_EXT]) ? {s_q.addr, pwdata[CTRL_MODE_LSB +: 8]}
                 : {s_q.addr[23:0], pwdata[CTRL_MODE_LSB +: 8], 8'h00};
        s_d.skew = HC_W'(SCK_HALF - 1);
        s_d.best = '0;
        s_d.learned = 1'b0;
      end
    end
    if (s_q.st == H_RUN) begin
      s_d.hc = tick ? '0 : s_q.hc + HC_W'(1);
      // Data of the latest edge is sampled at the learned offset in its half period.
      if (s_q.e != 20'h00000 && cur >= dm_end && cur < tot && s_q.hc == s_q.skew) begin
        s_d.rsr = {s_q.rsr[5:0], s_q.io_s};
        s_d.dc = s_q.dc + 2'h1;
        if (s_q.dc == 2'h3) begin
          s_d.rx = {s_q.rsr[5:0], s_q.io_s};
          s_d.overrun = s_d.overrun | s_d.valid;
          s_d.valid = 1'b1;
        end
      end
      // Preamble: first offset where a pattern transition is seen on both lines.
      if (s_q.ctrl[CTRL_PAT] && s_q.e != 20'h00000 && cur >= dm_end - PREAMBLE_EDGES
          && cur < dm_end) begin
        if (pidx != 3'h0 && expect_bit != s_q.pattern[3'h0 - pidx] && !s_q.found
            && s_q.io_s == {2{expect_bit}}) begin
          s_d.found = 1'b1;
          s_d.learned = 1'b1;
          if (s_q.hc > s_q.best) begin
            s_d.best = s_q.hc;
          end
        end
        if (tick && cur == dm_end - 20'h00001 && s_d.learned) begin
          s_d.skew = (s_d.best == HC_W'(SCK_HALF - 1)) ? s_d.best : s_d.best + HC_W'(1);
        end
      end
      if (tick) begin
        s_d.found = 1'b0;
        if (s_q.e < tot) begin
          s_d.sck = ~s_q.sck;
          s_d.e = s_q.e + 20'h00001;
          if (s_q.e < op_end) begin
            s_d.oe = 2'h1;
            if (!s_q.e[0]) begin
              s_d.out = {1'b0, s_q.op_sr[7]};
              s_d.op_sr = {s_q.op_sr[6:0], 1'b0};
            end
          end else if (s_q.e < md_end) begin
            s_d.oe = 2'h3;
            s_d.out = s_q.sh[39:38];
            s_d.sh = {s_q.sh[37:0], 2'h0};
          end else begin
            s_d.oe = 2'h0;
          end
        end else begin
          // Select rises only after the last data edge, never inside mode or dummy.
          s_d.cs_b = 1'b1;
          s_d.st = H_IDLE;
          s_d.oe = 2'h0;
          s_d.ctrl[CTRL_CONT] = s_q.ctrl[CTRL_ENH] && (mode_val[7:4] == ~mode_val[3:0]);
        end
      end
    end
  end

  // Register the whole state; the enable freezes everything.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{ctrl: CTRL_RESET, pattern: PATTERN_RESET, st: H_IDLE, cs_b: 1'b1,
               skew: HC_W'(SCK_HALF - 1), default: '0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign prdata = s_q.rdata;
  assign link.cs_b = s_q.cs_b;
  assign link.sck = s_q.sck;
  assign link.host_io_o = s_q.out;
  assign link.host_io_oe = s_q.oe;
endmodule
`default_nettype wire

//--- test/ddr_dual_link_assertions.sv
// Checker for the link between the dual-line host and the flash device.
// Assumes one clock domain and the link signals handed in by name.
`timescale 1ns/1ps
`default_nettype none
module ddr_dual_link_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link signals
  input wire logic cs_b,
  input wire logic sck,
  input wire logic [1:0] host_io_oe,
  input wire logic [1:0] dev_io_oe,
  // Device status
  input wire logic continuous_mode
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // All checks share the system clock and rest while reset is low.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_no_line_fight: assert property (!(|(host_io_oe & dev_io_oe))) else $error("line fight");
  a_dev_both_lines: assert property (dev_io_oe == 2'h0 || dev_io_oe == 2'h3)
    else $error("device drives one line only");
  a_host_lanes: assert property (host_io_oe != 2'h2) else $error("host lane wrong");
  a_sck_idle_low: assert property (cs_b |-> !sck) else $error("clock runs while idle");
  // A one-cycle clock phase is flagged although the rate limit allows it; each phase must last two cycles or more.
  a_sck_stretch: assert property ($changed(sck) |=> $stable(sck))
    else $error("clock phase too short");
  a_dev_quiet_start: assert property ($fell(cs_b) |-> (dev_io_oe == 2'h0) [*8])
    else $error("device drives early");
  a_opcode_lane: assert property ($fell(cs_b) && !continuous_mode |-> ##[1:12] host_io_oe == 2'h1)
    else $error("opcode not on one line");
  a_cont_skip: assert property ($fell(cs_b) && continuous_mode |-> ##[1:12] host_io_oe == 2'h3)
    else $error("opcode not skipped");
  a_sel_hold: assert property ($fell(cs_b) |=> !cs_b [*8]) else $error("select pulse short");

  // Main scenarios reached.
  c_cont_start: cover property ($fell(cs_b) && continuous_mode);
  c_dev_drive: cover property (dev_io_oe == 2'h3);
  c_cont_enter: cover property ($rose(continuous_mode));
endmodule
`default_nettype wire

//--- test/ddr_dual_io_flash_read_test.sv
// Testbench: host and device joined by the link, host driven over APB.
// Assumes zero-wait APB and one shared clock for both ends.
`timescale 1ns/1ps
`default_nettype none
module ddr_dual_io_flash_read_test;
  import ddr_dual_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready, pslverr, last_err, cont, busy;
  logic ext = 1'b0;
  logic enh = 1'b0;
  logic pat_en = 1'b0;
  logic pause_b = 1'b1;
  logic [1:0] lc = 2'h0;
  logic [7:0] pattern = 8'h34;
  int mismatches = 0;
  int n_tests = 0;

  ddr_dual_link_if u_ddr_dual_link_if ();
  ddr_dual_flash_host u_ddr_dual_flash_host (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(u_ddr_dual_link_if));
  ddr_dual_flash_dev u_ddr_dual_flash_dev (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .link(u_ddr_dual_link_if), .extended_address_setting(ext), .enhanced_latency_table(enh),
    .latency_code(lc), .learning_pattern_en(pat_en), .learning_pattern(pattern),
    .pause_b(pause_b), .continuous_mode(cont), .busy(busy));
  ddr_dual_link_assertions u_ddr_dual_link_assertions (.clk(clk), .rst_b(rst_b),
    .cs_b(u_ddr_dual_link_if.cs_b), .sck(u_ddr_dual_link_if.sck),
    .host_io_oe(u_ddr_dual_link_if.host_io_oe), .dev_io_oe(u_ddr_dual_link_if.dev_io_oe),
    .continuous_mode(cont));

  // Free-running 125 MHz clock.
  initial begin
    forever #4 clk = ~clk;
  end

  // Verdict; the only place where the run ends.
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Expected array byte: address bytes folded together, then inverted in a fixed mask.
  function automatic logic [31:0] fold(input logic [31:0] a);
    return {24'h000000, a[7:0] ^ a[15:8] ^ a[23:16] ^ {6'h00, a[25:24]} ^ 8'h5A};
  endfunction

  // One APB transfer; entered and left just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // Straps the device and programs the host to match, then runs one read to the end.
  task automatic go(input logic be, input logic e, input logic h, input logic p,
    input logic c, input logic [7:0] m, input logic [1:0] l, input logic [31:0] a,
    input logic [15:0] n, output logic [31:0] st);
    logic [31:0] q;
    logic [4:0] d;
    int k;
    ext <= e;
    enh <= h;
    pat_en <= p;
    lc <= l;
    d = 5'h05 + {3'h0, l} - {4'h0, h};
    apb(1'b1, REG_ADDR, a, q);
    apb(1'b1, REG_LEN, {16'h0000, n}, q);
    apb(1'b1, REG_CTRL, {11'h000, d, m, 2'h0, p, c, h, e, be, 1'b1}, q);
    k = 0;
    do begin
      apb(1'b0, REG_STATUS, 32'h00000000, st);
      k++;
    end while (st[STAT_BUSY] !== 1'b0 && k < 3000);
    chk("host idle", {31'h0, st[STAT_BUSY]}, 32'h00000000);
    // The device sees select through a short sync chain.
    repeat (8) @(posedge clk);
    chk("device idle", {31'h0, busy}, 32'h00000000);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    apb(1'b0, REG_CTRL, 32'h00000000, q);
    chk("ctrl reset", q, CTRL_RESET);
    apb(1'b0, REG_PATTERN, 32'h00000000, q);
    chk("pattern reset", q, {24'h000000, PATTERN_RESET});
    apb(1'b0, 8'h14, 32'h00000000, q);
    chk("unmapped read", {q[30:0], last_err}, 32'h00000001);
  endtask

  // Both opcodes, both address widths, every latency code.
  task automatic t_lat;
    logic [31:0] st, a;
    for (int i = 0; i < 16; i++) begin
      a = 32'h00012340 + 32'(i);
      go(i[3], i[2], 1'b0, 1'b0, 1'b0, 8'h00, i[1:0], a, 16'h0001, st);
      chk("latency byte", {24'h000000, st[15:8]}, fold(a));
    end
  endtask

  task automatic t_wrap;
    logic [31:0] st;
    go(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 2'h3, 32'h0000FFFE, 16'h0003, st);
    chk("increment byte", {24'h000000, st[15:8]}, fold(32'h00010000));
    go(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 2'h0, 32'h03FFFFFF, 16'h0002, st);
    chk("wrap byte", {24'h000000, st[15:8]}, fold(32'h00000000));
  endtask

  // Enter, use and leave continuous mode with pause held low throughout.
  task automatic t_cont;
    logic [31:0] st;
    pause_b <= 1'b0;
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'hA5, 2'h1, 32'h00000100, 16'h0001, st);
    chk("enter cont", {31'h0, cont}, 32'h00000001);
    chk("enh byte", {24'h000000, st[15:8]}, fold(32'h00000100));
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h5A, 2'h1, 32'h00000200, 16'h0001, st);
    chk("cont byte", {24'h000000, st[15:8]}, fold(32'h00000200));
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 8'h00, 2'h2, 32'h00000300, 16'h0001, st);
    chk("leave cont", {31'h0, cont}, 32'h00000000);
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 2'h3, 32'h00000400, 16'h0001, st);
    chk("opcode again", {24'h000000, st[15:8]}, fold(32'h00000400));
    pause_b <= 1'b1;
  endtask

  task automatic t_learn;
    logic [31:0] st, q;
    apb(1'b1, REG_PATTERN, 32'h000000C5, q);
    pattern <= 8'hC5;
    go(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 2'h2, 32'h00ABCDEF, 16'h0002, st);
    chk("learned", {31'h0, st[STAT_LEARNED]}, 32'h00000001);
    chk("learn byte", {24'h000000, st[15:8]}, fold(32'h00ABCDF0));
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset;
    t_lat;
    t_wrap;
    t_cont;
    t_learn;
    tally_and_finish;
  end

  // Watchdog, well beyond the expected length of the run.
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
